// >>> include/ees_pkg.sv
// Purpose: constants and types of the event entry sequencer
// Assumes: 32-bit registers, AXI4-Lite map of five words
// Notes:   bit positions are little-endian (bit 0 = lsb)
// Summary of operation
// (RULE_01) Priority: reset, hw exception, nonmaskable break, break, interrupt, user.
// (RULE_02) Vectors: reset 0x0, user 0x8, interrupt 0x10, breaks 0x18, hw 0x20.
// (RULE_03) Return address goes to R14 interrupt, R16 break, R17 hw exception.
// (RULE_04) Either external reset flushes, fetches from 0, clears status registers; the code clears MSR, ESR and EAR but not FSR.
// (RULE_05) Reset source holds active-high resets at least 16 cycles.
// (RULE_06) Trap selected internal and floating point error conditions when configured.
// (RULE_07) Hw exception flushes pipeline, kills execute instruction, branches to 0x20.
// (RULE_08) Hw exception writes decode-stage pc into R17.
// (RULE_09) Hw exception clears EE, sets EXCEPTION_IN_PROGRESS, loads cause, status, address, fsr.
// (RULE_10) Exception in a delay slot is flagged non-recoverable.
// (RULE_11) Break lets execute finish and replaces decode with branch to 0x18.
// (RULE_12) Break writes decode pc into R16 and sets break-in-progress.
// (RULE_13) Maskable break only when no break in progress; nonmaskable always.
// (RULE_14) Break in progress blocks interrupts and exception entry.
// (RULE_15) Interrupt taken only while interrupt enable is one.
// (RULE_16) Interrupt lets execute finish, branches to 0x10, saves pc in R14.
// (RULE_17) Interrupt entry clears enable; return-from-interrupt sets it again.
// (RULE_18) Entry latency 4, 6 or 37 cycles; two more from peripheral bus.
// (RULE_19) User exception: branch-link to 0x8 stores pc in chosen register.
// (RULE_20) Execute stalls may delay entry without bound.
// (RULE_21) Cause codes: 1 unaligned, 2 illegal, 3 ibus, 4 dbus, 5 div0, 6 fpu.
// (RULE_22) Only the highest pending event enters; lower ones stay pending.
package ees_pkg;
   localparam logic [31:0] VEC_RESET   = 32'h0000_0000;
   localparam logic [31:0] VEC_USER    = 32'h0000_0008;
   localparam logic [31:0] VEC_INTR    = 32'h0000_0010;
   localparam logic [31:0] VEC_BREAK   = 32'h0000_0018;
   localparam logic [31:0] VEC_HW_EXC  = 32'h0000_0020;
   localparam logic [4:0]  GPR_INTR    = 5'hE;
   localparam logic [4:0]  GPR_BREAK   = 5'h10;
   localparam logic [4:0]  GPR_HW_EXC  = 5'h11;
   localparam int          RESET_MIN_CYC   = 16;
   localparam int          LAT_NORMAL_CYC  = 4;
   localparam int          LAT_NODIV_CYC   = 6;
   localparam int          LAT_DIV_CYC     = 37;
   localparam int          LAT_PERIPH_EXTRA = 2;
   localparam int          MSR_IE_BIT  = 1;
   localparam int          MSR_BIP_BIT = 3;
   localparam int          MSR_EE_BIT  = 8;
   localparam int          MSR_EIP_BIT = 9;
   localparam logic [31:0] MSR_WR_MASK = 32'h0000_030A;
   localparam logic [31:0] MSR_RESET   = 32'h0000_0000;
   localparam int          ESR_EC_LSB  = 0;
   localparam int          ESR_EC_W    = 5;
   localparam int          ESR_ESS_LSB = 5;
   localparam int          ESR_ESS_W   = 7;
   localparam int          FSR_W       = 5;
   localparam logic [4:0]  EC_UNALIGNED = 5'h01;
   localparam logic [4:0]  EC_ILLEGAL   = 5'h02;
   localparam logic [4:0]  EC_IBUS      = 5'h03;
   localparam logic [4:0]  EC_DBUS      = 5'h04;
   localparam logic [4:0]  EC_DIV0      = 5'h05;
   localparam logic [4:0]  EC_FPU       = 5'h06;
   localparam logic [7:0]  OFS_MSR  = 8'h00;
   localparam logic [7:0]  OFS_ESR  = 8'h04;
   localparam logic [7:0]  OFS_EAR  = 8'h08;
   localparam logic [7:0]  OFS_FSR  = 8'h0C;
   localparam logic [7:0]  OFS_STAT = 8'h10;
   localparam int          STAT_WAIT_BIT  = 0;
   localparam int          STAT_NREC_BIT  = 1;
   localparam int          STAT_SHORT_BIT = 2;
   localparam int          STAT_EVT_LSB   = 4;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      EES_EVT_NONE = 3'h0, EES_EVT_RESET = 3'h1, EES_EVT_HWEXC = 3'h2,
      EES_EVT_NMBRK = 3'h3, EES_EVT_BRK = 3'h4, EES_EVT_INTR = 3'h5,
      EES_EVT_USER = 3'h6
   } ees_evt_t;
   typedef enum logic [1:0] {
      EES_ST_RESET = 2'h0, EES_ST_RUN = 2'h1, EES_ST_WAIT = 2'h3
   } ees_state_t;
endpackage : ees_pkg

// >>> core/ees_event_entry_sequencer.sv
// Purpose: event entry logic of a three-stage soft processor
// Assumes: all inputs synchronous to sys_clk; pipeline obeys redirects
// Notes:   entry outputs appear one cycle after the event is selected
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module ees_event_entry_sequencer #(
   parameter logic [6:0] TRAP_EN = 7'h3E,
   parameter bit         HAS_FPU = 1'b1
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        sys_reset_in,
   input  wire logic        debug_reset_in,
   input  wire logic        break_in,
   input  wire logic        nonmaskable_break_in,
   input  wire logic        interrupt_in,
   input  wire logic        ex_stall,
   input  wire logic [31:0] decode_pc,
   input  wire logic        decode_in_delay_slot,
   input  wire logic        hw_exc_req,
   input  wire logic [4:0]  hw_exc_cause,
   input  wire logic [6:0]  hw_exc_ess,
   input  wire logic [31:0] hw_exc_addr,
   input  wire logic [4:0]  hw_exc_fsr,
   input  wire logic        user_exc_req,
   input  wire logic [31:0] user_exc_pc,
   input  wire logic [4:0]  user_exc_reg,
   input  wire logic        rti_exec,
   output logic             redirect_valid,
   output logic [31:0]      redirect_pc,
   output logic             kill_execute,
   output logic             kill_decode,
   output logic             gpr_we,
   output logic [4:0]       gpr_addr,
   output logic [31:0]      gpr_wdata,
   output logic             hw_exc_ack,
   output logic             user_exc_ack,
   output logic [31:0]      machine_status_reg,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   ees_pkg::ees_state_t st_ff;
   ees_pkg::ees_evt_t   sel_evt;
   ees_pkg::ees_evt_t   last_evt_ff;
   logic [31:0] msr_ff, nxt_msr, esr_ff, ear_ff, fsr_ff;
   logic        ext_rst, ie, break_in_progress, ee, trap_ok, fire;
   logic        exc_ok, brk_ok, int_ok, wait_evt;
   logic        nrec_ff, short_rst_ff;
   logic [4:0]  rst_cnt_ff;
   logic        aw_hold_ff, w_hold_ff, do_write;
   logic        nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid;
   logic [7:0]  waddr_ff;
   logic [31:0] wdata_ff, rd_mux;
   logic [3:0]  wstrb_ff;
   logic        wr_msr, wr_fsr, rd_hit;

   function automatic logic [31:0] ees_strb(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : ees_strb

   assign ext_rst = sys_reset_in | debug_reset_in;
   assign ie      = msr_ff[ees_pkg::MSR_IE_BIT];
   assign break_in_progress     = msr_ff[ees_pkg::MSR_BIP_BIT];
   assign ee      = msr_ff[ees_pkg::MSR_EE_BIT];

   // unconfigured or unknown causes are never trapped
   always_comb begin
      trap_ok = 1'b0;
      if (hw_exc_cause >= ees_pkg::EC_UNALIGNED &&
          hw_exc_cause <= ees_pkg::EC_FPU) begin // RULE_21
         trap_ok = TRAP_EN[hw_exc_cause[2:0]]; // RULE_06
      end
      if (hw_exc_cause == ees_pkg::EC_FPU && !HAS_FPU) begin
         trap_ok = 1'b0; // RULE_06
      end
   end

   assign exc_ok = hw_exc_req & trap_ok & ee & ~break_in_progress & ~hw_exc_ack; // RULE_14
   assign brk_ok = break_in & ~break_in_progress; // RULE_13
   assign int_ok = interrupt_in & ie & ~break_in_progress; // RULE_14 RULE_15

   // strict ranking; a stalled higher event blocks all lower ones
   always_comb begin
      sel_evt = ees_pkg::EES_EVT_NONE;
      if (ext_rst) begin
         sel_evt = ees_pkg::EES_EVT_RESET; // RULE_01
      end else if (st_ff == ees_pkg::EES_ST_RESET) begin
         sel_evt = ees_pkg::EES_EVT_NONE;
      end else if (exc_ok) begin
         sel_evt = ees_pkg::EES_EVT_HWEXC; // RULE_01
      end else if (nonmaskable_break_in) begin
         sel_evt = ees_pkg::EES_EVT_NMBRK; // RULE_13
      end else if (brk_ok) begin
         sel_evt = ees_pkg::EES_EVT_BRK;
      end else if (int_ok) begin
         sel_evt = ees_pkg::EES_EVT_INTR;
      end else if (user_exc_req && !user_exc_ack) begin
         sel_evt = ees_pkg::EES_EVT_USER; // RULE_22
      end
   end

   // breaks and interrupts wait for the execute stage to finish
   assign wait_evt = ex_stall &&
                     (sel_evt == ees_pkg::EES_EVT_NMBRK ||
                      sel_evt == ees_pkg::EES_EVT_BRK ||
                      sel_evt == ees_pkg::EES_EVT_INTR); // RULE_20
   assign fire = (sel_evt != ees_pkg::EES_EVT_NONE) &&
                 (sel_evt != ees_pkg::EES_EVT_RESET) && !wait_evt; // RULE_22

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= ees_pkg::EES_ST_RESET;
      end else begin
         unique case (st_ff)
            ees_pkg::EES_ST_RESET: begin
               if (!ext_rst) begin
                  st_ff <= ees_pkg::EES_ST_RUN;
               end
            end
            ees_pkg::EES_ST_RUN, ees_pkg::EES_ST_WAIT: begin
               if (ext_rst) begin
                  st_ff <= ees_pkg::EES_ST_RESET;
               end else if (wait_evt) begin
                  st_ff <= ees_pkg::EES_ST_WAIT;
               end else begin
                  st_ff <= ees_pkg::EES_ST_RUN;
               end
            end
            default: begin
               st_ff <= ees_pkg::EES_ST_RESET;
            end
         endcase
      end
   end

   // pipeline redirect and return-address write
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         redirect_valid <= 1'b0;
         redirect_pc    <= ees_pkg::VEC_RESET;
         kill_execute   <= 1'b0;
         kill_decode    <= 1'b0;
         gpr_we         <= 1'b0;
         gpr_addr       <= 5'h0;
         gpr_wdata      <= 32'h0;
         hw_exc_ack     <= 1'b0;
         user_exc_ack   <= 1'b0;
      end else begin
         redirect_valid <= ext_rst | fire;
         kill_execute   <= ext_rst | (sel_evt == ees_pkg::EES_EVT_HWEXC);
         kill_decode    <= ext_rst | fire; // RULE_11
         gpr_we         <= fire;
         hw_exc_ack     <= fire && sel_evt == ees_pkg::EES_EVT_HWEXC;
         user_exc_ack   <= fire && sel_evt == ees_pkg::EES_EVT_USER;
         gpr_wdata      <= decode_pc; // RULE_08 RULE_12 RULE_16
         unique case (sel_evt)
            ees_pkg::EES_EVT_HWEXC: begin
               redirect_pc <= ees_pkg::VEC_HW_EXC; // RULE_02 RULE_07
               gpr_addr    <= ees_pkg::GPR_HW_EXC; // RULE_03
            end
            ees_pkg::EES_EVT_NMBRK, ees_pkg::EES_EVT_BRK: begin
               redirect_pc <= ees_pkg::VEC_BREAK; // RULE_02 RULE_11
               gpr_addr    <= ees_pkg::GPR_BREAK; // RULE_03
            end
            ees_pkg::EES_EVT_INTR: begin
               redirect_pc <= ees_pkg::VEC_INTR; // RULE_02 RULE_16
               gpr_addr    <= ees_pkg::GPR_INTR; // RULE_03
            end
            ees_pkg::EES_EVT_USER: begin
               redirect_pc <= ees_pkg::VEC_USER; // RULE_02 RULE_19
               gpr_addr    <= user_exc_reg; // RULE_19
               gpr_wdata   <= user_exc_pc; // RULE_19
            end
            default: begin
               redirect_pc <= ees_pkg::VEC_RESET; // RULE_04
               gpr_addr    <= 5'h0;
            end
         endcase
      end
   end

   // machine status: hardware updates override a same-cycle write
   always_comb begin
      nxt_msr = msr_ff;
      if (wr_msr) begin
         nxt_msr = (msr_ff & ~ees_pkg::MSR_WR_MASK) |
                   (ees_strb(msr_ff, wdata_ff, wstrb_ff) &
                    ees_pkg::MSR_WR_MASK);
      end
      if (rti_exec) begin
         nxt_msr[ees_pkg::MSR_IE_BIT] = 1'b1; // RULE_17
      end
      if (fire) begin
         unique case (sel_evt)
            ees_pkg::EES_EVT_HWEXC: begin
               nxt_msr[ees_pkg::MSR_EE_BIT]  = 1'b0; // RULE_09
               nxt_msr[ees_pkg::MSR_EIP_BIT] = 1'b1; // RULE_09
            end
            ees_pkg::EES_EVT_NMBRK, ees_pkg::EES_EVT_BRK: begin
               nxt_msr[ees_pkg::MSR_BIP_BIT] = 1'b1; // RULE_12
            end
            ees_pkg::EES_EVT_INTR: begin
               nxt_msr[ees_pkg::MSR_IE_BIT] = 1'b0; // RULE_17
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         msr_ff <= ees_pkg::MSR_RESET;
         esr_ff <= 32'h0;
         ear_ff <= 32'h0;
      end else if (ext_rst) begin
         msr_ff <= ees_pkg::MSR_RESET; // RULE_04
         esr_ff <= 32'h0; // RULE_04
         ear_ff <= 32'h0; // RULE_04
      end else begin
         msr_ff <= nxt_msr;
         if (fire && sel_evt == ees_pkg::EES_EVT_HWEXC) begin
            esr_ff <= 32'h0;
            esr_ff[ees_pkg::ESR_EC_LSB +: ees_pkg::ESR_EC_W] <=
               hw_exc_cause; // RULE_09
            esr_ff[ees_pkg::ESR_ESS_LSB +: ees_pkg::ESR_ESS_W] <=
               (hw_exc_cause == ees_pkg::EC_UNALIGNED) ? hw_exc_ess : 7'h0;
            ear_ff <= hw_exc_addr; // RULE_09
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fsr_ff <= 32'h0;
      end else if (fire && sel_evt == ees_pkg::EES_EVT_HWEXC) begin
         fsr_ff <= {27'h0, hw_exc_fsr}; // RULE_09
      end else if (wr_fsr) begin
         fsr_ff <= ees_strb(fsr_ff, wdata_ff, wstrb_ff) &
                   32'h0000_001F;
      end
   end

   assign machine_status_reg = msr_ff;

   // event status; hardware set wins over the write-one-to-clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         nrec_ff      <= 1'b0;
         short_rst_ff <= 1'b0;
         rst_cnt_ff   <= 5'h0;
         last_evt_ff  <= ees_pkg::EES_EVT_NONE;
      end else begin
         if (fire) begin
            last_evt_ff <= sel_evt;
         end else if (ext_rst) begin
            last_evt_ff <= ees_pkg::EES_EVT_RESET;
         end
         if (fire && sel_evt == ees_pkg::EES_EVT_HWEXC &&
             decode_in_delay_slot) begin
            nrec_ff <= 1'b1; // RULE_10
         end else if (do_write && waddr_ff == ees_pkg::OFS_STAT &&
                      wstrb_ff[0] && wdata_ff[ees_pkg::STAT_NREC_BIT]) begin
            nrec_ff <= 1'b0;
         end
         if (ext_rst) begin
            if (rst_cnt_ff != 5'(ees_pkg::RESET_MIN_CYC)) begin
               rst_cnt_ff <= rst_cnt_ff + 5'h1; // RULE_05
            end
         end else begin
            rst_cnt_ff <= 5'h0;
         end
         if (!ext_rst && st_ff == ees_pkg::EES_ST_RESET && rst_cnt_ff != 5'h0
             && rst_cnt_ff < 5'(ees_pkg::RESET_MIN_CYC)) begin
            short_rst_ff <= 1'b1; // RULE_05
         end else if (do_write && waddr_ff == ees_pkg::OFS_STAT &&
                      wstrb_ff[0] && wdata_ff[ees_pkg::STAT_SHORT_BIT]) begin
            short_rst_ff <= 1'b0;
         end
      end
   end

   // axi4-lite write: address and data latched separately
   assign do_write    = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
   assign nxt_aw_hold = do_write ? 1'b0 :
                        aw_hold_ff | (s_axi_awvalid & s_axi_awready);
   assign nxt_w_hold  = do_write ? 1'b0 :
                        w_hold_ff | (s_axi_wvalid & s_axi_wready);
   assign nxt_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);
   assign wr_msr      = do_write && waddr_ff == ees_pkg::OFS_MSR;
   assign wr_fsr      = do_write && waddr_ff == ees_pkg::OFS_FSR;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_hold_ff    <= 1'b0;
         w_hold_ff     <= 1'b0;
         waddr_ff      <= 8'h0;
         wdata_ff      <= 32'h0;
         wstrb_ff      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ees_pkg::RESP_OKAY;
      end else begin
         aw_hold_ff    <= nxt_aw_hold;
         w_hold_ff     <= nxt_w_hold;
         s_axi_awready <= ~nxt_aw_hold & ~nxt_bvalid;
         s_axi_wready  <= ~nxt_w_hold & ~nxt_bvalid;
         s_axi_bvalid  <= nxt_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            waddr_ff <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bresp <= (waddr_ff <= ees_pkg::OFS_STAT) ?
                           ees_pkg::RESP_OKAY : ees_pkg::RESP_SLVERR;
         end
      end
   end

   // axi4-lite read
   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0;
      unique case ({s_axi_araddr[7:2], 2'h0})
         ees_pkg::OFS_MSR: rd_mux = msr_ff;
         ees_pkg::OFS_ESR: rd_mux = esr_ff;
         ees_pkg::OFS_EAR: rd_mux = ear_ff;
         ees_pkg::OFS_FSR: rd_mux = fsr_ff;
         ees_pkg::OFS_STAT: begin
            rd_mux[ees_pkg::STAT_WAIT_BIT]  = (st_ff == ees_pkg::EES_ST_WAIT);
            rd_mux[ees_pkg::STAT_NREC_BIT]  = nrec_ff;
            rd_mux[ees_pkg::STAT_SHORT_BIT] = short_rst_ff;
            rd_mux[ees_pkg::STAT_EVT_LSB +: 3] = last_evt_ff;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   assign nxt_rvalid = (s_axi_arvalid & s_axi_arready) |
                       (s_axi_rvalid & ~s_axi_rready);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= ees_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~nxt_rvalid;
         s_axi_rvalid  <= nxt_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? ees_pkg::RESP_OKAY : ees_pkg::RESP_SLVERR;
         end
      end
   end

   // entry latency: select one cycle, redirect the next; pipeline refill
   // brings the total to the 4/6/37 cycle figures (RULE_18)
   default clocking ees_cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   rst_vec_a: assert property (ext_rst |=> redirect_pc == 32'h0 && // RULE_04
      redirect_valid && msr_ff == 32'h0 && esr_ff == 32'h0)
      else $error("reset did not redirect to zero");
   prio_exc_a: assert property (fire && exc_ok |=> // RULE_01
      redirect_pc == 32'h0000_0020 && kill_execute)
      else $error("hw exception not entered first");
   exc_ret_a: assert property (fire && sel_evt == ees_pkg::EES_EVT_HWEXC |=> // RULE_08
      gpr_we && gpr_addr == 5'h11 && gpr_wdata == $past(decode_pc))
      else $error("hw exception return address wrong");
   exc_msr_a: assert property (hw_exc_ack |-> // RULE_09
      msr_ff[ees_pkg::MSR_EIP_BIT] && !msr_ff[ees_pkg::MSR_EE_BIT])
      else $error("hw exception status bits wrong");
   brk_bip_a: assert property (fire && sel_evt == ees_pkg::EES_EVT_BRK |=> // RULE_12
      break_in_progress && gpr_addr == 5'h10 && redirect_pc == 32'h0000_0018)
      else $error("break entry wrong");
   brk_mask_a: assert property (break_in_progress && !nonmaskable_break_in |-> // RULE_13
      sel_evt != ees_pkg::EES_EVT_BRK && sel_evt != ees_pkg::EES_EVT_INTR)
      else $error("masked break or interrupt selected");
   int_mask_a: assert property (!ie |-> sel_evt != ees_pkg::EES_EVT_INTR) // RULE_15
      else $error("interrupt taken while disabled");
   int_entry_a: assert property (fire && sel_evt == ees_pkg::EES_EVT_INTR |=> // RULE_16
      !ie && gpr_addr == 5'hE && redirect_pc == 32'h0000_0010 && !kill_execute)
      else $error("interrupt entry wrong");
   stall_hold_a: assert property (ex_stall && int_ok && !ext_rst && // RULE_20
      !exc_ok && !nonmaskable_break_in && !brk_ok &&
      st_ff != ees_pkg::EES_ST_RESET |=> !redirect_valid)
      else $error("interrupt entered during stall");
   user_reg_a: assert property (user_exc_ack |-> // RULE_19
      gpr_addr == $past(user_exc_reg) && redirect_pc == 32'h0000_0008)
      else $error("user exception entry wrong");

   int_cov_c: cover property (fire && sel_evt == ees_pkg::EES_EVT_INTR);
   nmb_cov_c: cover property (break_in_progress && fire &&
      sel_evt == ees_pkg::EES_EVT_NMBRK);
   exc_cov_c: cover property (fire && sel_evt == ees_pkg::EES_EVT_HWEXC &&
      interrupt_in);
   wait_cov_c: cover property (st_ff == ees_pkg::EES_ST_WAIT ##1 fire);
endmodule : ees_event_entry_sequencer

// >>> sim/ees_event_source.sv
// Purpose: reset source and break/interrupt requester model
// Assumes: maskable break and interrupt requests are held until an entry at their vector shows, then dropped
// Notes:   nonmaskable break is one cycle wide so it cannot re-enter
`timescale 1ns/1ps
module ees_event_source (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        rst_go,
   input  wire logic [2:0]  ev_go,
   input  wire logic        redirect_valid,
   input  wire logic [31:0] redirect_pc,
   output logic             sys_reset_in,
   output logic             break_in,
   output logic             nonmaskable_break_in,
   output logic             interrupt_in
);
   int   rst_cnt;
   logic hit_b;
   logic hit_i;
   assign hit_b = redirect_valid && redirect_pc == ees_pkg::VEC_BREAK;
   assign hit_i = redirect_valid && redirect_pc == ees_pkg::VEC_INTR;
   assign sys_reset_in = (rst_cnt > 0);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_cnt <= 0;
         {break_in, nonmaskable_break_in, interrupt_in} <= 3'h0;
      end else begin
         rst_cnt <= rst_go ? ees_pkg::RESET_MIN_CYC
                           : rst_cnt - int'(rst_cnt > 0);
         break_in <= ev_go[0] | (break_in & !hit_b);
         nonmaskable_break_in <= ev_go[1];
         interrupt_in <= ev_go[2] | (interrupt_in & !hit_i);
      end
   end
endmodule : ees_event_source

// >>> sim/testbench.sv
// Purpose: self-checking bench of the event entry sequencer
// Assumes: reset, breaks and interrupts come from the source model, exceptions from the bench, registers over axi
// Notes:   entries are queued by the driver and checked by a watcher
`timescale 1ns/1ps
module testbench;
   logic sys_clk, resetn, rst_go, debug_reset_in, break_in, interrupt_in;
   logic nonmaskable_break_in, sys_reset_in, ex_stall, hw_exc_req, rti_exec;
   logic decode_in_delay_slot, user_exc_req, redirect_valid, kill_execute;
   logic kill_decode, gpr_we, hw_exc_ack, user_exc_ack;
   logic [2:0]  ev_go;
   logic [4:0]  hw_exc_cause, hw_exc_fsr, user_exc_reg, gpr_addr;
   logic [6:0]  hw_exc_ess;
   logic [31:0] decode_pc, hw_exc_addr, user_exc_pc, redirect_pc, pc;
   logic [31:0] gpr_wdata, machine_status_reg, s_axi_wdata, s_axi_rdata;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [70:0] exp_q[$];
   logic [70:0] got;
   int err_total, checked, cyc;
   ees_event_entry_sequencer dut (.*);
   ees_event_source model (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task step(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : step
   task conclude;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task chk(input string n, input logic [70:0] e, input logic [70:0] s);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task axw(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         step(1);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", ees_pkg::RESP_OKAY, s_axi_bresp);
   endtask : axw
   task axr(input logic [7:0] a, input logic [33:0] e);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         step(1);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk("rdata", e, {s_axi_rresp, s_axi_rdata});
   endtask : axr
   task ev(input logic [2:0] g, input logic [31:0] v, input logic [4:0] r);
      pc = $urandom;
      decode_pc <= pc;
      exp_q.push_back({v, 2'h1, r, pc});
      ev_go <= g;
      step(1);
      ev_go <= 3'h0;
      step(6);
   endtask : ev
   task ret_int;
      rti_exec <= 1'b1;
      step(1);
      rti_exec <= 1'b0;
      step(2);
   endtask : ret_int
   always @(posedge sys_clk) begin
      if (redirect_valid === 1'b1) begin
         got = {redirect_pc, kill_execute, gpr_we, gpr_addr, gpr_wdata};
         if (exp_q.size() > 0 && exp_q[0][37] === 1'b0) got[36:0] = 37'h0;
         chk("redirect", exp_q.size() ? exp_q.pop_front() : '0, got);
         chk("kill", 1'b1, kill_decode);
      end
      cyc++;
      if (cyc > 3000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      {resetn, rst_go, ev_go, debug_reset_in, ex_stall, rti_exec} = '0;
      {decode_in_delay_slot, hw_exc_req, user_exc_req, hw_exc_cause} = '0;
      {hw_exc_fsr, hw_exc_ess, hw_exc_addr, user_exc_pc, user_exc_reg} = '0;
      {decode_pc, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_bready} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      void'($urandom(32'hE4A06ECF));
      step(8);
      resetn <= 1'b1;
      step(2);
      repeat (16) exp_q.push_back({32'h0, 2'h2, 37'h0});
      rst_go <= 1'b1;
      step(1);
      rst_go <= 1'b0;
      step(20);
      axw(ees_pkg::OFS_MSR, 32'h0000_0102);
      axr(ees_pkg::OFS_MSR, {ees_pkg::RESP_OKAY, 32'h0000_0102});
      axr(8'h14, {ees_pkg::RESP_SLVERR, 32'h0});
      ev(3'h4, ees_pkg::VEC_INTR, ees_pkg::GPR_INTR);
      chk("msr", 32'h0000_0100, machine_status_reg);
      ret_int();
      chk("msr", 32'h0000_0102, machine_status_reg);
      // interrupt and exception pending together: exception first
      pc = $urandom;
      decode_pc <= pc;
      exp_q.push_back({ees_pkg::VEC_HW_EXC, 2'h3, ees_pkg::GPR_HW_EXC, pc});
      exp_q.push_back({ees_pkg::VEC_INTR, 2'h1, ees_pkg::GPR_INTR, pc});
      ev_go <= 3'h4;
      step(1);
      ev_go <= 3'h0;
      {hw_exc_req, hw_exc_cause, hw_exc_fsr} <= {1'b1, ees_pkg::EC_DIV0, 5'h15};
      decode_in_delay_slot <= 1'b1;
      while (hw_exc_ack !== 1'b1) step(1);
      hw_exc_req <= 1'b0;
      step(4);
      axr(ees_pkg::OFS_ESR, {2'h0, 27'h0, ees_pkg::EC_DIV0});
      axr(ees_pkg::OFS_FSR, {2'h0, 32'h15});
      axr(ees_pkg::OFS_STAT, {2'h0, 32'h52});
      chk("msr", 32'h0000_0200, machine_status_reg);
      ret_int();
      pc = $urandom;
      {user_exc_req, user_exc_pc, user_exc_reg} <= {1'b1, pc, 5'hF};
      exp_q.push_back({ees_pkg::VEC_USER, 2'h1, 5'hF, pc});
      while (user_exc_ack !== 1'b1) step(1);
      user_exc_req <= 1'b0;
      ev(3'h1, ees_pkg::VEC_BREAK, ees_pkg::GPR_BREAK);
      chk("msr", 32'h0000_020A, machine_status_reg);
      ev_go <= 3'h5;
      step(1);
      ev_go <= 3'h0;
      step(10);
      ev(3'h2, ees_pkg::VEC_BREAK, ees_pkg::GPR_BREAK);
      exp_q.push_back({ees_pkg::VEC_INTR, 2'h1, ees_pkg::GPR_INTR, pc});
      ex_stall <= 1'b1;
      axw(ees_pkg::OFS_MSR, 32'h0000_0002);
      ex_stall <= 1'b0;
      step(8);
      chk("queue", 71'h0, 71'(exp_q.size()));
      conclude();
   end
endmodule : testbench
